// ---- src/alu_mul_neg.sv ----
`timescale 1ns/1ps
module alu_mul_neg
(
  // operands
  input  wire logic [7:0]       workReg,
  input  wire logic [7:0]       operand,
  // results
  output logic [15:0]           product,
  output logic [7:0]            negValue,
  output exec_pkg::status_s     negFlags
);
  import exec_pkg::*;

  logic [8:0] negSum;
  logic [4:0] lowSum;

  // unsigned, 8 x 8 always fits 16 bits
  assign product = {8'h00, workReg} * {8'h00, operand};

  // inverse plus one, carries taken from the add itself
  assign negSum   = {1'b0, ~operand} + 9'h001;
  assign lowSum   = {1'b0, ~operand[3:0]} + 5'h01;
  assign negValue = negSum[7:0];

  assign negFlags.negative       = negSum[7];
  assign negFlags.overflowFlag   = operand[7] & negSum[7];
  assign negFlags.zero           = (negSum[7:0] == 8'h00);
  assign negFlags.digitCarryFlag = lowSum[4];
  assign negFlags.carry          = negSum[8];

endmodule : alu_mul_neg

// ---- src/exec_pkg.sv ----
package exec_pkg;

  localparam int INSTR_W     = 16;
  localparam int PC_W        = 21;
  localparam int ADDR_W      = 12;
  localparam int STACK_DEPTH = 31;

  // reset values
  localparam logic [PC_W-1:0] PC_RESET   = 21'h000000;
  localparam logic [7:0]      BANK_RESET = 8'h00;
  localparam logic [7:0]      WORK_RESET = 8'h00;
  localparam logic [7:0]      PROD_RESET = 8'h00;

  // one instruction word in byte addresses
  localparam logic [PC_W-1:0] PC_STEP = 21'h000002;

  // bank, access-bank and call-offset fields
  localparam logic [7:0] BANK_MASK      = 8'h0f;
  localparam logic [7:0] INDEX_LIMIT    = 8'h5f;
  localparam logic [3:0] ACCESS_HI_BANK = 4'hf;
  localparam logic [3:0] ACCESS_LO_BANK = 4'h0;
  localparam int         ACCESS_BIT     = 8;
  localparam int         OFFSET_MSB     = 10;

  // opcode patterns
  localparam logic [6:0]  OPC_MUL_FILE = 7'h01;
  localparam logic [6:0]  OPC_NEG_FILE = 7'h36;
  localparam logic [4:0]  OPC_REL_CALL = 5'h1b;
  localparam logic [3:0]  OPC_NO_OP_HI = 4'hf;
  localparam logic [15:0] OPC_NO_OP    = 16'h0000;
  localparam logic [15:0] OPC_PUSH     = 16'h0005;
  localparam logic [15:0] OPC_POP      = 16'h0006;
  localparam logic [15:0] OPC_RESET    = 16'h00ff;

  typedef enum logic [1:0] {Q1, Q2, Q3, Q4} phase_e;

  typedef enum logic [2:0] {
    OP_OTHER,
    OP_MUL,
    OP_NEG,
    OP_POP,
    OP_PUSH,
    OP_CALL,
    OP_RESET,
    OP_IDLE
  } op_e;

  typedef struct packed {
    logic negative;
    logic overflowFlag;
    logic zero;
    logic digitCarryFlag;
    logic carry;
  } status_s;

  localparam status_s STATUS_RESET = 5'h00;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic              read;
    logic              write;
    logic [7:0]        wdata;
  } mem_req_s;

  localparam mem_req_s MEM_REQ_IDLE = 22'h000000;

endpackage : exec_pkg

// ---- src/mul_negate_stack_call_exec.sv ----
`timescale 1ns/1ps
// Overview of operation
// - Pattern 0000 001a ffff ffff decodes as multiply W by file, bit a choosing the bank.
// - Multiply writes the unsigned 16-bit product of W and the file byte, high byte to product high.
// - Multiply leaves every status flag as it was.
// - Access bit 0 addresses the access bank, 1 uses the bank select register for the bank.
// - With the extended set on and access bit 0, file addresses up to 5Fh are offset from the index base.
// - Pattern 0110 110a ffff ffff writes back the inverse plus one of the file byte.
// - Pattern 0006h drops the top stack entry, exposing the one below, without loading the PC.
// - Pattern 0005h pushes the instruction address plus 2, moving the old top down.
// - Prefix 1101 1 decodes as relative call with an 11-bit signed word offset.
// - Relative call pushes PC plus 2, loads PC plus 2 plus twice the offset, then idles one cycle.
// - Pattern 00ffh resets in one cycle the PC, the bank select register and the stack; W, status and product keep their values.
// - The upper four bits of the bank select register always hold zero.
module mul_negate_stack_call_exec
(
  // clock and reset
  input  wire logic                            clock,
  input  wire logic                            resetn,
  // instruction fetch
  input  wire logic [exec_pkg::INSTR_W-1:0]    instrWord,
  output logic [exec_pkg::PC_W-1:0]            programCounter_q,
  output exec_pkg::phase_e                     phase_q,
  output logic                                 fetchFlush_q,
  // data memory
  output exec_pkg::mem_req_s                   memReq_q,
  input  wire logic [7:0]                      memRdata,
  input  wire logic [exec_pkg::ADDR_W-1:0]     indexBase,
  // configuration pin
  input  wire logic                            extInstrEnable,
  // loads from the rest of the core
  input  wire logic                            workLoadEn,
  input  wire logic [7:0]                      workLoadData,
  input  wire logic                            bankLoadEn,
  input  wire logic [7:0]                      bankLoadData,
  // architectural state
  output logic [7:0]                           workReg_q,
  output logic [7:0]                           bankSelectRegister_q,
  output logic [7:0]                           productHigh_q,
  output logic [7:0]                           productLow_q,
  output exec_pkg::status_s                    status_q,
  // return stack
  output logic [exec_pkg::PC_W-1:0]            topOfStack,
  output logic [$clog2(exec_pkg::STACK_DEPTH+1)-1:0] stackDepth,
  output logic                                 stackFull,
  output logic                                 stackUnderflow,
  // software reset towards the rest of the chip
  output logic                                 softReset_q
);
  import exec_pkg::*;

  // configuration pin synchroniser
  logic extSync1_q;
  logic extSync2_q;

  phase_e           phase_d;
  op_e              op_q;
  op_e              op_d;
  logic [15:0]      instr_q;
  logic [15:0]      instr_d;
  logic             fetchFlush_d;
  logic [PC_W-1:0]  programCounter_d;
  mem_req_s         memReq_d;
  logic [7:0]       workReg_d;
  logic [7:0]       bankSelectRegister_d;
  logic [7:0]       productHigh_d;
  logic [7:0]       productLow_d;
  status_s          status_d;
  logic             softReset_d;

  logic             stackPush;
  logic             stackPop;
  logic             stackClear;
  logic [PC_W-1:0]  returnAddr;
  logic [PC_W-1:0]  callOffset;
  logic [15:0]      product;
  logic [7:0]       negValue;
  status_s          negFlags;

  function automatic op_e decode(input logic [15:0] iw);
    op_e op;
    op = OP_OTHER;
    if (iw[15:9] == OPC_MUL_FILE)
      op = OP_MUL;
    else if (iw[15:9] == OPC_NEG_FILE)
      op = OP_NEG;
    else if (iw[15:11] == OPC_REL_CALL)
      op = OP_CALL;
    else if (iw == OPC_POP)
      op = OP_POP;
    else if (iw == OPC_PUSH)
      op = OP_PUSH;
    else if (iw == OPC_RESET)
      op = OP_RESET;
    else if (iw == OPC_NO_OP || iw[15:12] == OPC_NO_OP_HI)
      op = OP_IDLE;
    return op;
  endfunction : decode

  function automatic logic [ADDR_W-1:0] fileAddr(input logic [15:0]       iw,
                                                 input logic              ext,
                                                 input logic [7:0]        bank,
                                                 input logic [ADDR_W-1:0] base);
    logic [7:0]        f;
    logic [ADDR_W-1:0] addr;
    f = iw[7:0];
    // bank select when access bit set
    if (iw[ACCESS_BIT])
      addr = {bank[3:0], f};
    else if (ext && f <= INDEX_LIMIT)
      addr = base + {4'h0, f};
    else if (f[7])
      addr = {ACCESS_HI_BANK, f};
    else
      addr = {ACCESS_LO_BANK, f};
    return addr;
  endfunction : fileAddr

  assign returnAddr = programCounter_q + PC_STEP;
  // offset counts words, so shift left once
  assign callOffset = {{(PC_W - OFFSET_MSB - 2){instr_q[OFFSET_MSB]}}, instr_q[OFFSET_MSB:0], 1'b0};

  alu_mul_neg alu
  (
    .workReg  (workReg_q),
    .operand  (memRdata),
    .product  (product),
    .negValue (negValue),
    .negFlags (negFlags)
  );

  return_stack
  #(
    .DEPTH (STACK_DEPTH),
    .WIDTH (PC_W)
  )
  stack
  (
    .clock       (clock),
    .resetn      (resetn),
    .clear       (stackClear),
    .push        (stackPush),
    .pop         (stackPop),
    .pushData    (returnAddr),
    .top_q       (topOfStack),
    .depth_q     (stackDepth),
    .full_q      (stackFull),
    .underflow_q (stackUnderflow)
  );

  always_comb
  begin
    phase_d              = phase_q;
    op_d                 = op_q;
    instr_d              = instr_q;
    fetchFlush_d         = fetchFlush_q;
    programCounter_d     = programCounter_q;
    memReq_d             = memReq_q;
    memReq_d.read        = 1'b0;
    memReq_d.write       = 1'b0;
    workReg_d            = workReg_q;
    bankSelectRegister_d = bankSelectRegister_q;
    productHigh_d        = productHigh_q;
    productLow_d         = productLow_q;
    status_d             = status_q;
    softReset_d          = 1'b0;
    stackPush            = 1'b0;
    stackPop             = 1'b0;
    stackClear           = 1'b0;

    // loads by other instructions land in any quarter
    if (workLoadEn)
      workReg_d = workLoadData;
    if (bankLoadEn)
      bankSelectRegister_d = bankLoadData & BANK_MASK;

    unique case (phase_q)
      Q1:
      begin
        phase_d = Q2;
        instr_d = instrWord;
        // dead second cycle of a call
        op_d = fetchFlush_q ? OP_IDLE : decode(instrWord);
        if (!fetchFlush_q && (decode(instrWord) == OP_MUL || decode(instrWord) == OP_NEG))
        begin
          memReq_d.read = 1'b1;
          memReq_d.addr = fileAddr(instrWord, extSync2_q, bankSelectRegister_q, indexBase);
        end
      end
      Q2:
      begin
        phase_d = Q3;
        if (op_q == OP_PUSH || op_q == OP_CALL)
          stackPush = 1'b1;
        if (op_q == OP_RESET)
        begin
          phase_d              = Q1;
          op_d                 = OP_OTHER;
          fetchFlush_d         = 1'b0;
          programCounter_d     = PC_RESET;
          bankSelectRegister_d = BANK_RESET;
          stackClear           = 1'b1;
          softReset_d          = 1'b1;
        end
      end
      Q3:
      begin
        phase_d = Q4;
        if (op_q == OP_POP)
          stackPop = 1'b1;
        if (op_q == OP_MUL)
        begin
          productHigh_d = product[15:8];
          productLow_d  = product[7:0];
        end
        if (op_q == OP_NEG)
        begin
          memReq_d.write = 1'b1;
          memReq_d.wdata = negValue;
          status_d = negFlags;
        end
      end
      Q4:
      begin
        phase_d = Q1;
        // call target then one idle cycle
        fetchFlush_d = (op_q == OP_CALL);
        if (op_q == OP_CALL)
          programCounter_d = returnAddr + callOffset;
        else if (!fetchFlush_q)
          programCounter_d = returnAddr;
      end
    endcase
  end

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      extSync1_q <= 1'b0;
      extSync2_q <= 1'b0;
    end
    else
    begin
      extSync1_q <= extInstrEnable;
      extSync2_q <= extSync1_q;
    end
  end

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      phase_q              <= Q1;
      op_q                 <= OP_OTHER;
      instr_q              <= 16'h0000;
      fetchFlush_q         <= 1'b0;
      programCounter_q     <= PC_RESET;
      memReq_q             <= MEM_REQ_IDLE;
      workReg_q            <= WORK_RESET;
      bankSelectRegister_q <= BANK_RESET;
      productHigh_q        <= PROD_RESET;
      productLow_q         <= PROD_RESET;
      status_q             <= STATUS_RESET;
      softReset_q          <= 1'b0;
    end
    else
    begin
      phase_q              <= phase_d;
      op_q                 <= op_d;
      instr_q              <= instr_d;
      fetchFlush_q         <= fetchFlush_d;
      programCounter_q     <= programCounter_d;
      memReq_q             <= memReq_d;
      workReg_q            <= workReg_d;
      bankSelectRegister_q <= bankSelectRegister_d;
      productHigh_q        <= productHigh_d;
      productLow_q         <= productLow_d;
      status_q             <= status_d;
      softReset_q          <= softReset_d;
    end
  end

endmodule : mul_negate_stack_call_exec

// ---- src/return_stack.sv ----
`timescale 1ns/1ps
module return_stack
#(
  parameter  int DEPTH = exec_pkg::STACK_DEPTH,
  parameter  int WIDTH = exec_pkg::PC_W,
  localparam int PTR_W = $clog2(DEPTH + 1)
)
(
  // clock and reset
  input  wire logic             clock,
  input  wire logic             resetn,
  // operations
  input  wire logic             clear,
  input  wire logic             push,
  input  wire logic             pop,
  input  wire logic [WIDTH-1:0] pushData,
  // state
  output logic [WIDTH-1:0]      top_q,
  output logic [PTR_W-1:0]      depth_q,
  output logic                  full_q,
  output logic                  underflow_q
);
  import exec_pkg::*;

  logic [WIDTH-1:0] entries [DEPTH];
  logic [WIDTH-1:0] top_d;
  logic [PTR_W-1:0] depth_d;
  logic             full_d;
  logic             underflow_d;
  logic             writeEn;

  always_comb
  begin
    top_d       = top_q;
    depth_d     = depth_q;
    full_d      = full_q;
    underflow_d = underflow_q;
    writeEn     = 1'b0;
    if (clear)
    begin
      top_d       = '0;
      depth_d     = '0;
      full_d      = 1'b0;
      underflow_d = 1'b0;
    end
    else if (push)
    begin
      // a push into a full stack is dropped, not wrapped
      if (depth_q == PTR_W'(DEPTH))
        full_d = 1'b1;
      else
      begin
        writeEn = 1'b1;
        depth_d = PTR_W'(depth_q + 1'b1);
        top_d   = pushData;
      end
    end
    else if (pop)
    begin
      if (depth_q == '0)
        underflow_d = 1'b1;
      else
      begin
        depth_d = PTR_W'(depth_q - 1'b1);
        top_d   = (depth_q > PTR_W'(1)) ? entries[PTR_W'(depth_q - 2'd2)] : '0;
      end
    end
  end

  always_ff @(posedge clock)
  begin
    if (writeEn)
      entries[depth_q] <= pushData;
  end

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      top_q       <= '0;
      depth_q     <= '0;
      full_q      <= 1'b0;
      underflow_q <= 1'b0;
    end
    else
    begin
      top_q       <= top_d;
      depth_q     <= depth_d;
      full_q      <= full_d;
      underflow_q <= underflow_d;
    end
  end

endmodule : return_stack

// ---- tb/mul_negate_stack_call_exec_properties.sv ----
`timescale 1ns/1ps
module mul_negate_stack_call_exec_properties
(
  // clock and reset
  input wire logic                                       clock,
  input wire logic                                       resetn,
  // watched ports
  input wire logic [exec_pkg::PC_W-1:0]                  programCounter_q,
  input wire exec_pkg::phase_e                           phase_q,
  input wire logic                                       fetchFlush_q,
  input wire exec_pkg::mem_req_s                         memReq_q,
  input wire logic [7:0]                                 memRdata,
  input wire logic [7:0]                                 workReg_q,
  input wire logic [7:0]                                 bankSelectRegister_q,
  input wire logic [7:0]                                 productHigh_q,
  input wire logic [7:0]                                 productLow_q,
  input wire exec_pkg::status_s                          status_q,
  input wire logic [$clog2(exec_pkg::STACK_DEPTH+1)-1:0] stackDepth,
  input wire logic                                       softReset_q
);
  import exec_pkg::*;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  property p_bank_hi; bankSelectRegister_q[7:4] == 4'h0; endproperty
  a_bank_hi: assert property (p_bank_hi) else $error("bank select upper bits set");
  property p_read_q2; memReq_q.read |-> phase_q == Q2; endproperty
  a_read_q2: assert property (p_read_q2) else $error("read strobe outside second quarter");
  property p_write_q4; memReq_q.write |-> phase_q == Q4; endproperty
  a_write_q4: assert property (p_write_q4) else $error("write strobe outside fourth quarter");
  property p_phase; phase_q == Q3 |=> phase_q == Q4 ##1 phase_q == Q1; endproperty
  a_phase: assert property (p_phase) else $error("quarter sequence broken");
  property p_neg_value; memReq_q.write |-> memReq_q.wdata == (~$past(memRdata) + 8'h01); endproperty
  a_neg_value: assert property (p_neg_value) else $error("negate result wrong");
  property p_mul_value;
    $changed({productHigh_q, productLow_q}) |->
      {productHigh_q, productLow_q} == 16'(workReg_q) * 16'($past(memRdata)) && phase_q == Q4;
  endproperty
  a_mul_value: assert property (p_mul_value) else $error("product wrong");
  property p_status; $changed(status_q) |-> memReq_q.write; endproperty
  a_status: assert property (p_status) else $error("status changed without negate");
  property p_pc; $changed(programCounter_q) |-> $past(phase_q) == Q4 || softReset_q; endproperty
  a_pc: assert property (p_pc) else $error("program counter moved mid cycle");
  property p_flush; $rose(fetchFlush_q) |-> phase_q == Q1 ##0 fetchFlush_q [*4] ##1 !fetchFlush_q; endproperty
  a_flush: assert property (p_flush) else $error("dead cycle length wrong");
  property p_soft;
    softReset_q |-> programCounter_q == PC_RESET && bankSelectRegister_q == BANK_RESET && stackDepth == 0
      && phase_q == Q1 ##1 !softReset_q;
  endproperty
  a_soft: assert property (p_soft) else $error("software reset state wrong");
  c_mul: cover property ($changed({productHigh_q, productLow_q}));
  c_neg: cover property (memReq_q.write);
  c_call: cover property ($rose(fetchFlush_q));
  c_soft: cover property (softReset_q);
endmodule : mul_negate_stack_call_exec_properties

bind mul_negate_stack_call_exec mul_negate_stack_call_exec_properties u_props (
  .clock(clock), .resetn(resetn), .programCounter_q(programCounter_q), .phase_q(phase_q),
  .fetchFlush_q(fetchFlush_q), .memReq_q(memReq_q), .memRdata(memRdata), .workReg_q(workReg_q),
  .bankSelectRegister_q(bankSelectRegister_q), .productHigh_q(productHigh_q), .productLow_q(productLow_q),
  .status_q(status_q), .stackDepth(stackDepth), .softReset_q(softReset_q));

// ---- tb/mul_negate_stack_call_exec_test.sv ----
`timescale 1ns/1ps
module mul_negate_stack_call_exec_test;
  import exec_pkg::*;
  logic clock = 1'b0, resetn = 1'b0, extInstrEnable = 1'b0, workLoadEn = 1'b0, bankLoadEn = 1'b0;
  logic [INSTR_W-1:0] instrWord = OPC_NO_OP;
  logic [7:0] memRdata = 8'h00, workLoadData = 8'h00, bankLoadData = 8'h00;
  logic [ADDR_W-1:0] indexBase = 12'h000;
  logic [PC_W-1:0] programCounter_q, topOfStack, expPc, lastTop;
  phase_e phase_q;
  mem_req_s memReq_q;
  status_s status_q, oldStatus;
  logic [7:0] workReg_q, bankSelectRegister_q, productHigh_q, productLow_q;
  logic [$clog2(STACK_DEPTH+1)-1:0] stackDepth;
  logic fetchFlush_q, stackFull, stackUnderflow, softReset_q;
  logic [7:0] mem [0:4095];
  logic [ADDR_W-1:0] seenAddr;
  logic [31:0] lfsrState = 32'h44be9ef2;
  int bad_count = 0, compares = 0, cycles = 0;
  localparam logic [7:0] CORNER_D [8] = '{8'hb5, 8'h00, 8'h80, 8'h3a, 8'h01, 8'h7f, 8'hf0, 8'hff};
  localparam logic [7:0] CORNER_F [8] = '{8'h5f, 8'h60, 8'h80, 8'h7f, 8'h00, 8'h5f, 8'hff, 8'h12};
  localparam logic [10:0] OFFSETS [4] = '{11'h400, 11'h3ff, 11'h001, 11'h7ff};

  mul_negate_stack_call_exec uut (
    .clock(clock), .resetn(resetn), .instrWord(instrWord), .programCounter_q(programCounter_q),
    .phase_q(phase_q), .fetchFlush_q(fetchFlush_q), .memReq_q(memReq_q), .memRdata(memRdata),
    .indexBase(indexBase), .extInstrEnable(extInstrEnable), .workLoadEn(workLoadEn),
    .workLoadData(workLoadData), .bankLoadEn(bankLoadEn), .bankLoadData(bankLoadData),
    .workReg_q(workReg_q), .bankSelectRegister_q(bankSelectRegister_q), .productHigh_q(productHigh_q),
    .productLow_q(productLow_q), .status_q(status_q), .topOfStack(topOfStack), .stackDepth(stackDepth),
    .stackFull(stackFull), .stackUnderflow(stackUnderflow), .softReset_q(softReset_q));

  always #2.5 clock = ~clock;

  // file memory; data stays on the bus through the third quarter
  always @(posedge clock)
  begin
    memRdata <= mem[memReq_q.addr];
    if (memReq_q.write === 1'b1)
      mem[memReq_q.addr] <= memReq_q.wdata;
  end

  always @(posedge clock)
  begin
    cycles = cycles + 1;
    if (cycles == 6000)
    begin
      bad_count = bad_count + 1;
      tally_and_finish();
    end
  end

  function automatic logic [31:0] next_rand(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : next_rand

  function automatic logic [ADDR_W-1:0] file_addr(input logic a, input logic [7:0] f, input logic [7:0] b,
                                                  input logic e, input logic [ADDR_W-1:0] base);
    if (a)
      return {b[3:0], f};
    if (e && f <= 8'h5f)
      return base + {4'h0, f};
    return {(f >= 8'h80) ? 4'hf : 4'h0, f};
  endfunction : file_addr

  function automatic status_s neg_flags(input logic [7:0] op);
    logic [7:0] res;
    res = ~op + 8'h01;
    return '{negative: res[7], overflowFlag: op == 8'h80, zero: res == 8'h00,
             digitCarryFlag: op[3:0] == 4'h0, carry: op == 8'h00};
  endfunction : neg_flags

  // wide enough for the longest packed comparison, so nothing is cut off
  task automatic check(input logic [39:0] seen, input logic [39:0] expVal);
    compares = compares + 1;
    if (seen !== expVal)
    begin
      bad_count = bad_count + 1;
      $display("BAD at %0t: seen %h expected %h", $time, seen, expVal);
    end
  endtask : check

  task automatic tally_and_finish();
    if (bad_count == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : tally_and_finish

  // one instruction; returns in its fourth quarter, nop word left behind
  task automatic run(input logic [15:0] w);
    int n;
    n = 0;
    while (phase_q !== Q4 && n < 16)
    begin
      @(negedge clock);
      n++;
    end
    @(posedge clock);
    instrWord <= w;
    @(negedge clock);
    check(programCounter_q, expPc);
    expPc = expPc + PC_STEP;
    @(posedge clock);
    instrWord <= OPC_NO_OP;
    @(negedge clock);
    seenAddr = memReq_q.addr;
    repeat (2) @(negedge clock);
  endtask : run

  // loads land during a filler nop cycle
  task automatic load(input logic [7:0] w, input logic [7:0] b, input logic e, input logic [ADDR_W-1:0] base);
    @(posedge clock);
    {workLoadEn, workLoadData, bankLoadEn, bankLoadData} <= {1'b1, w, 1'b1, b};
    {extInstrEnable, indexBase} <= {e, base};
    @(posedge clock);
    {workLoadEn, bankLoadEn} <= 2'b00;
    @(negedge clock);
    check(bankSelectRegister_q, b & BANK_MASK);
    expPc = expPc + PC_STEP;
  endtask : load

  initial
  begin
    logic [7:0] f, d, w;
    logic [ADDR_W-1:0] addr;
    logic a;
    repeat (16) @(posedge clock);
    resetn <= 1'b1;
    @(negedge clock);
    check({programCounter_q, bankSelectRegister_q, stackDepth}, '0);
    // first load overlaps the nop cycle fetched at the reset address
    expPc = PC_RESET;
    for (int i = 0; i < 32; i++)
    begin
      lfsrState = next_rand(next_rand(lfsrState));
      f = (i < 16) ? CORNER_F[i % 8] : lfsrState[7:0];
      d = (i < 16) ? CORNER_D[i % 8] : lfsrState[15:8];
      w = (i == 0) ? 8'hc4 : lfsrState[23:16];
      a = (i < 8) ? i[3] : lfsrState[24];
      load(w, lfsrState[31:24], (i < 8) ? 1'b1 : lfsrState[25], lfsrState[11:0]);
      addr = file_addr(a, f, lfsrState[31:24], (i < 8) ? 1'b1 : lfsrState[25], lfsrState[11:0]);
      mem[addr] = d;
      oldStatus = status_q;
      run(i[0] ? {OPC_NEG_FILE, a, f} : {OPC_MUL_FILE, a, f});
      check(seenAddr, addr);
      check(workReg_q, w);
      check(memReq_q.write, i[0]);
      if (i[0])
      begin
        check(memReq_q.wdata, 8'(~d + 8'h01));
        check(status_q, neg_flags(d));
      end
      else
      begin
        check({productHigh_q, productLow_q}, 16'(w) * 16'(d));
        check(status_q, oldStatus);
      end
    end
    run(OPC_PUSH);
    check(topOfStack, expPc);
    lastTop = topOfStack;
    run(OPC_PUSH);
    check({topOfStack, stackDepth}, {expPc, 5'd2});
    run(OPC_POP);
    check({topOfStack, stackDepth}, {lastTop, 5'd1});
    run(16'hd0ff);
    check(stackDepth, 5'd1);
    for (int k = 0; k < 4; k++)
    begin
      run({OPC_REL_CALL, OFFSETS[k]});
      check({topOfStack, stackDepth}, {expPc, 5'(k + 2)});
      // dead cycle already shows the call target
      expPc = expPc + {{9{OFFSETS[k][10]}}, OFFSETS[k], 1'b0};
      run(OPC_PUSH);
      check({fetchFlush_q, stackDepth}, {1'b1, 5'(k + 2)});
      expPc = expPc - PC_STEP;
    end
    run(OPC_NO_OP);
    oldStatus = status_q;
    w = workReg_q;
    @(posedge clock);
    instrWord <= OPC_RESET;
    @(posedge clock);
    instrWord <= OPC_NO_OP;
    repeat (2) @(negedge clock);
    check({softReset_q, phase_q, programCounter_q, bankSelectRegister_q, stackDepth}, {1'b1, Q1, 34'h0});
    check({workReg_q, status_q}, {w, oldStatus});
    expPc = PC_RESET + PC_STEP;
    run(OPC_PUSH);
    check({topOfStack, stackDepth}, {expPc, 5'd1});
    run(OPC_POP);
    run(OPC_POP);
    check({stackUnderflow, stackFull, stackDepth, topOfStack}, {2'b10, 5'd0, 21'h0});
    run(16'hf35a);
    run(OPC_NO_OP);
    tally_and_finish();
  end
endmodule : mul_negate_stack_call_exec_test
